// ### inc/isv_pkg.sv
/*
 * Constants shared by the interrupt source and vectoring block: register map,
 * reset values, source table with vector numbers and priority bit selects.
 * Assumes a 32-bit APB with byte addresses and one register per aligned word.
 */
package isv_pkg;

    // Register byte offsets
    localparam logic [7:0] OFF_SYSTEM_CONTROL_REG = 8'h00;
    localparam logic [7:0] OFF_PIN_SENSE_CONTROL = 8'h04;
    localparam logic [7:0] OFF_PIN_REQUEST_ENABLE = 8'h08;
    localparam logic [7:0] OFF_PIN_REQUEST_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_PRIORITY_REG_A = 8'h10;
    localparam logic [7:0] OFF_PRIORITY_REG_B = 8'h14;
    localparam logic [7:0] OFF_VECTOR_STATUS = 8'h18;

    // Field positions in the system control register
    localparam int SYS_NMI_EDGE_SELECT_BIT = 0;
    localparam int SYS_USER_MASK_SELECT_BIT = 1;

    // Values after reset and hardware standby
    localparam logic [7:0] SYSTEM_CONTROL_RESET = 8'h02;
    localparam logic [7:0] PLAIN_REG_RESET = 8'h00;

    // Source counts
    localparam int PIN_COUNT = 5;
    localparam int INTERNAL_COUNT = 21;
    localparam int SOURCE_COUNT = 27;
    localparam int SYNC_WIDTH = 6;

    localparam logic [5:0] NMI_VECTOR = 6'h07;

    // Vector number of each source, index 0 is the non-maskable request
    localparam logic [5:0] SRC_VEC [SOURCE_COUNT] = '{
        6'h07, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h10, 6'h14,
        6'h18, 6'h19, 6'h1A, 6'h1C, 6'h1D, 6'h1E, 6'h20, 6'h21, 6'h22,
        6'h24, 6'h25, 6'h26, 6'h28, 6'h29, 6'h2A,
        6'h34, 6'h35, 6'h36, 6'h37, 6'h3C};

    // Priority bit per source: bit 3 selects register B, bits 2:0 the bit
    localparam logic [3:0] SRC_PBIT [SOURCE_COUNT] = '{
        4'h0, 4'h7, 4'h6, 4'h5, 4'h5, 4'h4, 4'h3,
        4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0,
        4'hF, 4'hF, 4'hF, 4'hE, 4'hE, 4'hE,
        4'hB, 4'hB, 4'hB, 4'hB, 4'h9};

endpackage

// ### inc/isv_pin_if.sv
/*
 * Carrier for the filtered pin levels between the synchroniser and the core.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface isv_pin_if;
    logic [isv_pkg::SYNC_WIDTH-1:0] level; // Bit 0 non-maskable pin, 5:1 request pins

    modport sync (output level);
    modport core (input level);
endinterface

// ### design/isv_pin_sync.sv
/*
 * Three-stage synchroniser for the interrupt pins with agreement filter.
 * Assumes the pins are asynchronous to CLOCK; one clock, async active-low reset.
 */
`timescale 1ns/1ps
module isv_pin_sync (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [isv_pkg::SYNC_WIDTH-1:0] pins,
    isv_pin_if.sync out
);
    typedef struct packed {
        logic [isv_pkg::SYNC_WIDTH-1:0] s1;
        logic [isv_pkg::SYNC_WIDTH-1:0] s2;
        logic [isv_pkg::SYNC_WIDTH-1:0] s3;
        logic [isv_pkg::SYNC_WIDTH-1:0] level;
    } isv_sync_t;

    isv_sync_t s_q;
    isv_sync_t s_d;

    // A change counts only once stages two and three agree; stage one feeds stage two only
    always_comb begin
        s_d = s_q;
        s_d.s1 = pins;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        for (int i = 0; i < isv_pkg::SYNC_WIDTH; i++) begin
            if (s_q.s2[i] == s_q.s3[i]) begin
                s_d.level[i] = s_q.s3[i];
            end
        end
    end

    // Pins idle high, so reset to high avoids a false falling edge at release
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    assign out.level = s_q.level;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    // Checked per bit: a pin whose stages agree may move while another one disagrees
    chk_sync_agree_hold: assert property ((s_q.s2 != s_q.s3) |=>
        ((($past(s_q.s2) ^ $past(s_q.s3)) & ($past(s_q.level) ^ s_q.level)) == '0))
        else $error("Filtered level changed while stages disagreed");
endmodule

// ### design/isv_core.sv
/*
 * Interrupt source collection, sensing, prioritising and vectoring with an APB
 * register slave. Assumes one 100 MHz clock, pins synchronised here, internal
 * requests and core mask bits arriving from logic on the same clock.
 */
// Function
// [R1] Non-maskable request has top priority and ignores core and user masks.
// [R2] Non-maskable request is taken on rising or falling pin edge per edge select.
// [R3] Non-maskable request is delivered as vector number 7.
// [R4] Non-maskable and pin requests 0 to 2 wake from software standby; 3, 4 do not.
// [R5] Each request pin senses low level or falling edge, chosen per pin.
// [R6] A pin request reaches prioritisation only when its enable bit is set.
// [R7] Each pin request is recorded in a flag; software may clear it to 0.
// [R8] Pin requests 0 to 4 use vector numbers 12 to 16.
// [R9] Pin requests are sensed whatever the pin direction setting.
// [R10] Twenty-one internal requests count only when flagged and enabled.
// [R11] Within a level, the smaller vector number wins.
// [R12] Priority registers move every source except the non-maskable one.
// [R13] After reset all levels are low and default vector order applies.
// [R14] Vector address low 16 bits equal four times the vector number.
// [R15] Pins 0,1,4, watchdog, timers 0 to 2 map to priority A bits.
// [R16] Timers 3, 4, serial unit and converter map to priority B bits.
// [R17] Flag sets on low level or falling edge; clears by software or level ack.
// [R18] Pin requests 2 and 3 share one priority bit.
// [R19] Level-1 sources win over level-0 sources pending together.
// [R20] With core mask set, user mask decides if level-1 requests pass.
// [R21] Losers stay pending; one winning vector is presented each cycle.
`timescale 1ns/1ps
module isv_core (
    input wire logic CLOCK,
    input wire logic RESET_N,
    input wire logic HW_STANDBY,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic NMI_PIN,
    input wire logic [4:0] IRQ_PIN_N,
    input wire logic [20:0] INT_FLAG,
    input wire logic [20:0] INT_EN,
    input wire logic MASK_I,
    input wire logic USER_MASK_BIT,
    input wire logic EXC_ACK,
    output logic IRQ_REQ,
    output logic [5:0] VECTOR_NUM,
    output logic [15:0] VECTOR_ADDR,
    output logic STANDBY_WAKE
);
    typedef struct packed {
        logic [7:0] sysctl;
        logic [7:0] sense;
        logic [7:0] enable;
        logic [7:0] pra;
        logic [7:0] prb;
        logic [4:0] flags;
        logic [4:0] seen;
        logic nmi_pend;
        logic [5:0] prev;
        logic irq;
        logic [5:0] vec;
        logic [15:0] addr;
        logic wake;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } isv_state_t;

    isv_state_t s_q;
    isv_state_t s_d;

    isv_pin_if pin_bus ();

    // Pin levels cross into the clock domain here; direction bits are never looked at
    isv_pin_sync u_sync ( // R9
        .clock(CLOCK),
        .reset_n(RESET_N),
        .pins({IRQ_PIN_N, NMI_PIN}),
        .out(pin_bus)
    );

    // Constant state after reset or hardware standby: low levels, default order
    function automatic isv_state_t reset_state();
        isv_state_t r;
        r = '0;
        r.sysctl = isv_pkg::SYSTEM_CONTROL_RESET;
        r.sense = isv_pkg::PLAIN_REG_RESET;
        r.enable = isv_pkg::PLAIN_REG_RESET;
        r.pra = isv_pkg::PLAIN_REG_RESET; // R13
        r.prb = isv_pkg::PLAIN_REG_RESET; // R13
        r.prev = '1;
        return r;
    endfunction

    // Priority level of a source from its register and bit select
    function automatic logic src_level(input int idx, input logic [7:0] pra,
                                       input logic [7:0] prb);
        logic [3:0] sel;
        sel = isv_pkg::SRC_PBIT[idx];
        if (idx == 0) begin
            return 1'b0; // R12
        end
        return sel[3] ? prb[sel[2:0]] : pra[sel[2:0]]; // R15 R16 R18
    endfunction

    // Lowest index set in a mask; index order is vector order
    function automatic logic [4:0] pick_first(input logic [isv_pkg::SOURCE_COUNT-1:0] m);
        logic [4:0] idx;
        idx = '0;
        for (int i = isv_pkg::SOURCE_COUNT - 1; i >= 0; i--) begin
            if (m[i]) begin
                idx = 5'(i); // R11
            end
        end
        return idx;
    endfunction

    logic [5:0] lvl_now;
    logic [isv_pkg::SOURCE_COUNT-1:0] req;
    logic [isv_pkg::SOURCE_COUNT-1:0] lvl;
    logic [isv_pkg::SOURCE_COUNT-1:0] acc;
    logic [isv_pkg::SOURCE_COUNT-1:0] hi;
    logic [4:0] win;
    logic [4:0] flag_set;
    logic [4:0] ack_clr;
    logic [4:0] sw_clr;
    logic nmi_edge;
    logic apb_setup;
    logic apb_access;
    logic wr_flags;
    logic rd_flags;
    logic ack_nmi;
    logic ue;

    assign lvl_now = pin_bus.level;
    assign ue = s_q.sysctl[isv_pkg::SYS_USER_MASK_SELECT_BIT];

    // Selected edge of the filtered non-maskable pin
    assign nmi_edge = s_q.sysctl[isv_pkg::SYS_NMI_EDGE_SELECT_BIT]
        ? (!s_q.prev[0] && lvl_now[0])
        : (s_q.prev[0] && !lvl_now[0]); // R2

    // APB phases; the answer is ready in the first access cycle
    assign apb_setup = PSEL && !PENABLE;
    assign apb_access = PSEL && PENABLE && s_q.pready;
    assign wr_flags = apb_access && PWRITE && (PADDR == isv_pkg::OFF_PIN_REQUEST_FLAGS);
    assign rd_flags = apb_access && !PWRITE && (PADDR == isv_pkg::OFF_PIN_REQUEST_FLAGS);
    assign ack_nmi = EXC_ACK && s_q.irq && (s_q.vec == isv_pkg::NMI_VECTOR);

    // Per-pin set and clear terms
    generate
        for (genvar p = 0; p < isv_pkg::PIN_COUNT; p++) begin : g_pin
            assign flag_set[p] = s_q.sense[p]
                ? (s_q.prev[p+1] && !lvl_now[p+1])
                : !lvl_now[p+1]; // R5 R17
            assign ack_clr[p] = EXC_ACK && s_q.irq && (s_q.vec == isv_pkg::SRC_VEC[p+1])
                && !s_q.sense[p] && lvl_now[p+1]; // R17
            assign sw_clr[p] = wr_flags && !PWDATA[p] && s_q.seen[p]; // R7 R17
        end
    endgenerate

    // Request vector: pending non-maskable, enabled pin flags and enabled internal requests
    always_comb begin
        req = '0;
        req[0] = s_q.nmi_pend; // R1
        req[5:1] = s_q.flags & s_q.enable[4:0]; // R6
        req[26:6] = INT_FLAG & INT_EN; // R10
    end

    // Masking by core mask, user mask select and user mask bit
    generate
        for (genvar i = 0; i < isv_pkg::SOURCE_COUNT; i++) begin : g_src
            assign lvl[i] = src_level(i, s_q.pra, s_q.prb);
            if (i == 0) begin : g_nmi
                assign acc[i] = req[i]; // R1
            end else begin : g_mask
                assign acc[i] = req[i]
                    && (!MASK_I || (!ue && !USER_MASK_BIT && lvl[i])); // R20
            end
        end
    endgenerate

    assign hi = acc & lvl;

    // Non-maskable first, then level 1, then level 0
    assign win = acc[0] ? 5'h00 : (|hi ? pick_first(hi) : pick_first(acc)); // R1 R19 R21

    // Next-state logic for registers, flags, arbitration and the bus answer
    always_comb begin
        s_d = s_q;
        s_d.prev = lvl_now;
        s_d.nmi_pend = nmi_edge || (s_q.nmi_pend && !ack_nmi); // R1 R2
        // Set wins over any clear in the same cycle
        s_d.flags = flag_set | (s_q.flags & ~sw_clr & ~ack_clr); // R7 R17
        s_d.seen = (rd_flags ? (s_q.seen | s_q.prdata[4:0]) : s_q.seen) & s_d.flags;
        // One winner per cycle; the rest stay in req until they win
        s_d.irq = |acc; // R21
        s_d.vec = isv_pkg::SRC_VEC[win]; // R3 R8 R11
        s_d.addr = {8'h00, isv_pkg::SRC_VEC[win], 2'b00}; // R14
        // Wake sources are the non-maskable and the first three pins only
        s_d.wake = s_q.nmi_pend || |(s_q.flags[2:0] & s_q.enable[2:0]); // R4
        s_d.pready = apb_setup;
        if (apb_setup) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = '0;
            case (PADDR)
                isv_pkg::OFF_SYSTEM_CONTROL_REG: begin
                    s_d.prdata[7:0] = s_q.sysctl;
                end
                isv_pkg::OFF_PIN_SENSE_CONTROL: begin
                    s_d.prdata[7:0] = s_q.sense;
                end
                isv_pkg::OFF_PIN_REQUEST_ENABLE: begin
                    s_d.prdata[7:0] = s_q.enable;
                end
                isv_pkg::OFF_PIN_REQUEST_FLAGS: begin
                    s_d.prdata[4:0] = s_q.flags; // Upper bits read as zero
                end
                isv_pkg::OFF_PRIORITY_REG_A: begin
                    s_d.prdata[7:0] = s_q.pra;
                end
                isv_pkg::OFF_PRIORITY_REG_B: begin
                    s_d.prdata[7:0] = s_q.prb;
                end
                isv_pkg::OFF_VECTOR_STATUS: begin
                    s_d.prdata[15:0] = {s_q.nmi_pend, s_q.flags, s_q.vec, 3'h0, s_q.irq};
                end
                default: begin
                    s_d.pslverr = 1'b1; // Unmapped address
                end
            endcase
        end
        // Writes land only on the access edge; the flag register only clears
        if (apb_access && PWRITE && !s_q.pslverr) begin
            case (PADDR)
                isv_pkg::OFF_SYSTEM_CONTROL_REG: begin
                    s_d.sysctl = PWDATA[7:0];
                end
                isv_pkg::OFF_PIN_SENSE_CONTROL: begin
                    s_d.sense = PWDATA[7:0];
                end
                isv_pkg::OFF_PIN_REQUEST_ENABLE: begin
                    s_d.enable = PWDATA[7:0];
                end
                isv_pkg::OFF_PRIORITY_REG_A: begin
                    s_d.pra = PWDATA[7:0]; // R12
                end
                isv_pkg::OFF_PRIORITY_REG_B: begin
                    s_d.prb = PWDATA[7:0]; // R12
                end
                default: begin
                end
            endcase
        end
        if (HW_STANDBY) begin
            s_d = reset_state(); // R13
            // The synchroniser is not cleared, so take the live levels: no false edge after standby
            s_d.prev = lvl_now;
        end
    end

    // State register
    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q <= reset_state(); // R13
        end else begin
            s_q <= s_d;
        end
    end

    // Every output straight from the state register
    assign PRDATA = s_q.prdata;
    assign PREADY = s_q.pready;
    assign PSLVERR = s_q.pslverr;
    assign IRQ_REQ = s_q.irq;
    assign VECTOR_NUM = s_q.vec;
    assign VECTOR_ADDR = s_q.addr;
    assign STANDBY_WAKE = s_q.wake;

    // Checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    logic [4:0] hi_first;
    assign hi_first = pick_first(hi);

    chk_nmi_top_vector: assert property ( // R1 R3
        (s_q.nmi_pend && !HW_STANDBY) |=> (IRQ_REQ && VECTOR_NUM == 6'h07))
        else $error("Pending non-maskable request not presented as vector 7");

    chk_vector_addr_pair: assert property ( // R14
        IRQ_REQ |-> (VECTOR_ADDR == {8'h00, VECTOR_NUM, 2'b00}))
        else $error("Vector address is not four times the vector number");

    chk_enable_gates_pin: assert property ( // R6 R8
        (IRQ_REQ && VECTOR_NUM == 6'h0C) |-> $past(s_q.enable[0]))
        else $error("Pin request 0 presented while disabled");

    chk_edge_sets_flag: assert property ( // R5 R17
        (s_q.sense[0] && s_q.prev[1] && !lvl_now[1] && !HW_STANDBY) |=> s_q.flags[0])
        else $error("Falling edge on pin 0 did not set its flag");

    chk_mask_all_block: assert property ( // R20
        (ue && MASK_I && !s_q.nmi_pend && !HW_STANDBY) |=> !IRQ_REQ)
        else $error("Maskable request passed a full mask");

    chk_level_one_first: assert property ( // R19 R11
        (|hi && !s_q.nmi_pend && !HW_STANDBY) |=> (VECTOR_NUM == $past(isv_pkg::SRC_VEC[hi_first])))
        else $error("Level-1 winner not the lowest vector");

    chk_soft_clear_flag: assert property ( // R7
        (sw_clr[0] && !flag_set[0] && !HW_STANDBY) |=> !s_q.flags[0])
        else $error("Software clear of flag 0 did not take effect");

    chk_apb_ready_next: assert property (
        (apb_setup ##1 PSEL && PENABLE) |-> PREADY)
        else $error("APB access phase without ready");

    cov_nmi_taken: cover property (IRQ_REQ && VECTOR_NUM == 6'h07 && EXC_ACK);
    cov_level_one_win: cover property (|hi && |(acc & ~lvl & ~27'h1));
    cov_soft_clear: cover property (sw_clr != 5'h00);
endmodule

// ### bench/isv_core_model.sv
/*
 * Processor core model: takes the presented vector after a set delay.
 * Assumes one clock shared with the block and an active-low reset.
 */
`timescale 1ns/1ps
module isv_core_model (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic irq_req,
    input wire logic [5:0] vector_num,
    input wire logic ack_on,
    input wire logic [3:0] ack_delay,
    output logic exc_ack,
    output logic [5:0] taken_vec,
    output logic [7:0] taken_cnt
);
    logic [3:0] wait_q;
    logic [1:0] hold_q;

    // One pulse per request; the hold-off lets the cleared source leave
    // the outputs first, as a real core is busy stacking meanwhile
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wait_q <= 4'h0;
            hold_q <= 2'h0;
            exc_ack <= 1'b0;
            taken_vec <= 6'h00;
            taken_cnt <= 8'h00;
        end else if (exc_ack) begin
            exc_ack <= 1'b0;
            taken_vec <= vector_num;
            taken_cnt <= taken_cnt + 8'h01;
            hold_q <= 2'h3;
            wait_q <= 4'h0;
        end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
        end else if (irq_req && ack_on) begin
            if (wait_q >= ack_delay) begin
                exc_ack <= 1'b1;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// ### bench/interrupt_source_vectoring_tb.sv
/*
 * Self-checking bench for the interrupt source and vectoring block.
 * Assumes an APB slave that answers within 20 access cycles, and the core model beside it.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %0t got=%h exp=%h", $time, got, exp); end end
module interrupt_source_vectoring_tb;
    logic CLOCK = 1'b0;
    logic RESET_N = 1'b0;
    logic HW_STANDBY = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY, PSLVERR, EXC_ACK, IRQ_REQ, STANDBY_WAKE;
    logic NMI_PIN = 1'b1;
    logic [4:0] IRQ_PIN_N = 5'h1F;
    logic [20:0] INT_FLAG = 21'h0;
    logic [20:0] INT_EN = 21'h0;
    logic MASK_I = 1'b0;
    logic USER_MASK_BIT = 1'b0;
    logic [5:0] VECTOR_NUM, taken_vec;
    logic [15:0] VECTOR_ADDR;
    logic ack_on = 1'b0;
    logic [3:0] ack_delay = 4'h4;
    logic [7:0] taken_cnt;
    logic [31:0] rd;
    logic err;
    int fails = 0;
    int check_count = 0;
    // Priority A, priority B, expected winner with pins 3 and 4 low
    logic [23:0] prio_tab [10] = '{24'h100010, 24'h080014, 24'h040018, 24'h02001C,
        24'h010020, 24'h008024, 24'h004028, 24'h000834, 24'h00023C, 24'h20020F};

    // Clock at 100 MHz
    always #5 CLOCK = ~CLOCK;

    isv_core u_isv_core (.CLOCK(CLOCK), .RESET_N(RESET_N), .HW_STANDBY(HW_STANDBY),
        .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
        .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .NMI_PIN(NMI_PIN),
        .IRQ_PIN_N(IRQ_PIN_N), .INT_FLAG(INT_FLAG), .INT_EN(INT_EN), .MASK_I(MASK_I),
        .USER_MASK_BIT(USER_MASK_BIT), .EXC_ACK(EXC_ACK), .IRQ_REQ(IRQ_REQ),
        .VECTOR_NUM(VECTOR_NUM), .VECTOR_ADDR(VECTOR_ADDR), .STANDBY_WAKE(STANDBY_WAKE));

    isv_core_model u_isv_core_model (.clock(CLOCK), .reset_n(RESET_N), .irq_req(IRQ_REQ),
        .vector_num(VECTOR_NUM), .ack_on(ack_on), .ack_delay(ack_delay), .exc_ack(EXC_ACK),
        .taken_vec(taken_vec), .taken_cnt(taken_cnt));

    task automatic close_out();
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // APB transfer; the request stands until PREADY is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLOCK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            fails++;
            close_out();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, 32'h0);
        `CHK(rd, exp)
        `CHK(err, e)
    endtask

    // Bounded wait for a given winner, then its number and table address
    task automatic wait_vec(input logic [5:0] exp);
        int n;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (!(IRQ_REQ === 1'b1 && VECTOR_NUM === exp) && n < 60);
        if (!(IRQ_REQ === 1'b1 && VECTOR_NUM === exp)) begin
            fails++;
            close_out();
        end
        `CHK(VECTOR_NUM, exp)
        `CHK(VECTOR_ADDR, {8'h00, exp, 2'b00})
    endtask

    task automatic wait_ack(input logic [5:0] exp);
        logic [7:0] c0;
        int n;
        c0 = taken_cnt;
        n = 0;
        do begin
            @(posedge CLOCK);
            n++;
        end while (taken_cnt === c0 && n < 60);
        if (taken_cnt === c0) begin
            fails++;
            close_out();
        end
        `CHK(taken_vec, exp)
    endtask

    // Long enough for a pin edge to cross the synchroniser and reach the outputs
    task automatic idle_chk();
        repeat (10) @(posedge CLOCK);
        `CHK(IRQ_REQ, 1'b0)
    endtask

    task automatic t_reset();
        rd_chk(isv_pkg::OFF_SYSTEM_CONTROL_REG, 32'h2, 1'b0);
        rd_chk(isv_pkg::OFF_PRIORITY_REG_A, 32'h0, 1'b0);
        rd_chk(isv_pkg::OFF_PRIORITY_REG_B, 32'h0, 1'b0);
        rd_chk(isv_pkg::OFF_PIN_REQUEST_FLAGS, 32'h0, 1'b0);
        rd_chk(8'h1C, 32'h0, 1'b1);
        `CHK(IRQ_REQ, 1'b0)
    endtask

    // Non-maskable request through both masks, on either edge
    task automatic t_nmi();
        @(posedge CLOCK);
        MASK_I <= 1'b1;
        USER_MASK_BIT <= 1'b1;
        NMI_PIN <= 1'b0;
        wait_vec(6'h07);
        ack_on <= 1'b1;
        wait_ack(6'h07);
        idle_chk();
        wr(isv_pkg::OFF_SYSTEM_CONTROL_REG, 32'h3);
        NMI_PIN <= 1'b1;
        wait_vec(6'h07);
        wait_ack(6'h07);
        NMI_PIN <= 1'b0;
        idle_chk();
        ack_on <= 1'b0;
        MASK_I <= 1'b0;
        USER_MASK_BIT <= 1'b0;
        wr(isv_pkg::OFF_SYSTEM_CONTROL_REG, 32'h2);
    endtask

    // Each pin in edge mode, a disabled pin, then level clear by acknowledge
    task automatic t_pins();
        wr(isv_pkg::OFF_PIN_SENSE_CONTROL, 32'h1F);
        wr(isv_pkg::OFF_PIN_REQUEST_ENABLE, 32'h1F);
        for (int k = 0; k < 5; k++) begin
            IRQ_PIN_N[k] <= 1'b0;
            wait_vec(6'(12 + k));
            `CHK(STANDBY_WAKE, k < 3)
            @(posedge CLOCK);
            IRQ_PIN_N[k] <= 1'b1;
            rd_chk(isv_pkg::OFF_PIN_REQUEST_FLAGS, 32'h1 << k, 1'b0);
            wr(isv_pkg::OFF_PIN_REQUEST_FLAGS, 32'h0);
            idle_chk();
        end
        wr(isv_pkg::OFF_PIN_REQUEST_ENABLE, 32'h0);
        IRQ_PIN_N[1] <= 1'b0;
        idle_chk();
        rd_chk(isv_pkg::OFF_PIN_REQUEST_FLAGS, 32'h2, 1'b0);
        IRQ_PIN_N[1] <= 1'b1;
        wr(isv_pkg::OFF_PIN_REQUEST_FLAGS, 32'h0);
        wr(isv_pkg::OFF_PIN_SENSE_CONTROL, 32'h0);
        wr(isv_pkg::OFF_PIN_REQUEST_ENABLE, 32'h1);
        IRQ_PIN_N[0] <= 1'b0;
        wait_vec(6'h0C);
        @(posedge CLOCK);
        IRQ_PIN_N[0] <= 1'b1;
        repeat (6) @(posedge CLOCK);
        ack_delay <= 4'h0;
        ack_on <= 1'b1;
        wait_ack(6'h0C);
        idle_chk();
        ack_on <= 1'b0;
    endtask

    // Internal requests, priority levels, masks and standby
    task automatic t_prio();
        INT_FLAG <= 21'h1FFFFF;
        idle_chk();
        INT_EN <= 21'h1FFFFF;
        wait_vec(6'h14);
        wr(isv_pkg::OFF_PIN_REQUEST_ENABLE, 32'h18);
        IRQ_PIN_N <= 5'h07;
        wait_vec(6'h0F);
        for (int i = 0; i < 10; i++) begin
            wr(isv_pkg::OFF_PRIORITY_REG_A, {24'h0, prio_tab[i][23:16]});
            wr(isv_pkg::OFF_PRIORITY_REG_B, {24'h0, prio_tab[i][15:8]});
            wait_vec(prio_tab[i][5:0]);
        end
        wr(isv_pkg::OFF_PRIORITY_REG_A, 32'h0);
        MASK_I <= 1'b1;
        idle_chk();
        wr(isv_pkg::OFF_SYSTEM_CONTROL_REG, 32'h0);
        wait_vec(6'h3C);
        USER_MASK_BIT <= 1'b1;
        idle_chk();
        MASK_I <= 1'b0;
        USER_MASK_BIT <= 1'b0;
        NMI_PIN <= 1'b1;
        repeat (6) @(posedge CLOCK);
        NMI_PIN <= 1'b0;
        wait_vec(6'h07);
        ack_on <= 1'b1;
        wait_ack(6'h07);
        ack_on <= 1'b0;
        wait_vec(6'h3C);
        @(posedge CLOCK);
        HW_STANDBY <= 1'b1;
        @(posedge CLOCK);
        HW_STANDBY <= 1'b0;
        rd_chk(isv_pkg::OFF_SYSTEM_CONTROL_REG, 32'h2, 1'b0);
        rd_chk(isv_pkg::OFF_PRIORITY_REG_B, 32'h0, 1'b0);
        wait_vec(6'h14);
        // Pins 3 and 4 still low in level mode: flags set, no pending non-maskable
        rd_chk(isv_pkg::OFF_VECTOR_STATUS, 32'h6141, 1'b0);
    endtask

    // Main sequence: reset held for four cycles, then the scenarios
    initial begin
        repeat (4) @(posedge CLOCK);
        RESET_N <= 1'b1;
        t_reset();
        t_nmi();
        t_pins();
        t_prio();
        close_out();
    end

    // Hang guard
    initial begin
        repeat (50000) @(posedge CLOCK);
        fails++;
        close_out();
    end
endmodule
